// [sscb_sram_ctrl.sv]
// Synchronous burst SRAM bus control: select, write, output drive, sleep.
// Function
// R1: Master waits at least 1 ms after power-up before any access.
// R2: Selected only with primary enable low, high enable high, third low.
// R3: All lanes written on global write low, or gate low with lanes low.
// R4: After a write, data outputs stay off until a new strobed read.
// R5: Output enable asynchronously gates the data drivers on and off.
// R6: Master keeps the device deselected when asserting the sleep input.
// R7: Data lines stay at high impedance when leaving sleep.
// R8: In sleep, synchronous inputs are ignored and no access is done.
`timescale 1ns/100ps
module sscb_sram_ctrl #(
    parameter int POWER_WAIT_CYCLES = sscb_pkg::POWER_UP_WAIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic primary_select_n_i,
    input wire logic expansion_select_high_i,
    input wire logic expansion_select_n_i,
    input wire logic cpu_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire logic [sscb_pkg::ADDR_W-1:0] addr_i,
    input wire logic all_lanes_write_n_i,
    input wire logic lane_write_gate_n_i,
    input wire logic [sscb_pkg::LANES-1:0] lane_write_n_i,
    input wire logic [sscb_pkg::DATA_W-1:0] data_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic read_ready_i,
    output logic [sscb_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic read_valid_o,
    output logic access_ready_o,
    output logic sleeping_o
);
    import sscb_pkg::*;

    sscb_stream_if fill_s ();
    sscb_stream_if drain_s ();

    logic [DATA_W-1:0] array_reg [2**ADDR_W];
    sscb_state_t state_reg;
    sscb_state_t state_next;
    logic [WAIT_CNT_W-1:0] wait_reg;
    logic [WAIT_CNT_W-1:0] wait_next;
    logic drive_reg;
    logic drive_next;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] data_next;
    logic selected;
    logic strobe;
    logic access;
    logic [LANES-1:0] lane_we;
    logic is_write;
    logic is_read;

    // A deselect on any one enable drops the whole device.
    function automatic logic chip_selected(input logic p_n, input logic h,
                                           input logic e_n);
        return !p_n && h && !e_n;
    endfunction

    assign selected = chip_selected(primary_select_n_i, // R2
                                    expansion_select_high_i,
                                    expansion_select_n_i);
    assign strobe = !cpu_addr_strobe_n_i || !ctrl_addr_strobe_n_i;
    // Accesses are only taken in the active state, which excludes sleep.
    assign access = (state_reg == SSCB_ACTIVE) && selected && strobe; // R8

    always_comb begin
        if (!all_lanes_write_n_i) begin
            lane_we = '1; // R3
        end else if (!lane_write_gate_n_i) begin
            lane_we = ~lane_write_n_i; // R3
        end else begin
            lane_we = '0;
        end
    end

    assign is_write = access && (lane_we != '0);
    // A read that finds the buffer full is not taken; the master must
    // watch access_ready_o, since the SRAM pins have no wait signal.
    assign is_read = access && (lane_we == '0) && fill_s.ready;

    assign fill_s.valid = is_read;
    assign fill_s.data = array_reg[addr_i];
    // The receiver's ready is a synchronous input too, so sleep freezes it.
    assign drain_s.ready = read_ready_i && !sleeping_o; // R8

    sscb_read_buffer u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_s(fill_s),
        .out_s(drain_s)
    );

    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        drive_next = drive_reg;
        data_next = drain_s.data;
        case (state_reg)
            SSCB_POWERUP: begin
                // The wait is the master's duty; counting it here keeps a
                // premature access from ever touching the array.
                if (wait_reg == WAIT_CNT_W'(POWER_WAIT_CYCLES - 1)) begin
                    state_next = SSCB_ACTIVE; // R1
                end else begin
                    wait_next = wait_reg + 1'b1; // R1
                end
            end
            SSCB_ACTIVE: begin
                if (sleep_request_i) begin
                    state_next = SSCB_SLEEP; // R6
                    drive_next = 1'b0;
                end else if (is_write) begin
                    drive_next = 1'b0; // R4
                end else if (is_read) begin
                    drive_next = 1'b1; // R4
                end
            end
            SSCB_SLEEP: begin
                drive_next = 1'b0; // R7
                if (!sleep_request_i) begin
                    state_next = SSCB_ACTIVE; // R8
                end
            end
            default: begin
                state_next = SSCB_POWERUP;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SSCB_POWERUP;
            wait_reg <= WAIT_CNT_RST;
            drive_reg <= 1'b0;
            data_reg <= DATA_RST;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            drive_reg <= drive_next;
            data_reg <= data_next;
        end
    end

    // The array is not reset; only lanes named by the write are updated.
    always_ff @(posedge clk_i) begin
        for (int l = 0; l < LANES; l++) begin
            if (is_write && lane_we[l]) begin
                array_reg[addr_i][l*LANE_W +: LANE_W] <=
                    data_i[l*LANE_W +: LANE_W];
            end
        end
    end

    assign data_o = data_reg;
    // Output enable is not sampled, so it cuts the drivers at once.
    assign data_oe_o = drive_reg && read_valid_o &&
                       !output_enable_n_i && !sleeping_o; // R5 R7
    assign read_valid_o = drain_s.valid;
    assign access_ready_o = (state_reg == SSCB_ACTIVE) && fill_s.ready;
    assign sleeping_o = (state_reg == SSCB_SLEEP);
endmodule // sscb_sram_ctrl

// [sscb_pkg.sv]
// Shared constants and types for the synchronous SRAM bus control block.
package sscb_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int CLK_KHZ = 250000;
    localparam int POWER_UP_WAIT_MS = 1;
    localparam int POWER_UP_WAIT_CYC = POWER_UP_WAIT_MS * CLK_KHZ;
    localparam int WAIT_CNT_W = 18;
    localparam int BUF_DEPTH = 2;
    localparam logic [WAIT_CNT_W-1:0] WAIT_CNT_RST = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;

    typedef enum logic [2:0] {
        SSCB_POWERUP = 3'b001,
        SSCB_ACTIVE = 3'b010,
        SSCB_SLEEP = 3'b100
    } sscb_state_t;
endpackage

// [sscb_stream_if.sv]
// Valid/ready word stream between the access logic and the read buffer.
`timescale 1ns/100ps
interface sscb_stream_if;
    logic valid;
    logic ready;
    logic [sscb_pkg::DATA_W-1:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );
    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface

// [sscb_read_buffer.sv]
// Two-entry read-data buffer with valid and ready on both sides.
`timescale 1ns/100ps
module sscb_read_buffer (
    input wire logic clk_i,
    input wire logic rst_i,
    sscb_stream_if.snk in_s,
    sscb_stream_if.src out_s
);
    import sscb_pkg::*;

    logic [DATA_W-1:0] mem_reg [BUF_DEPTH];
    logic [DATA_W-1:0] mem_next [BUF_DEPTH];
    logic wr_ptr_reg;
    logic wr_ptr_next;
    logic rd_ptr_reg;
    logic rd_ptr_next;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic push;
    logic pop;

    assign in_s.ready = (count_reg != 2'h2);
    assign out_s.valid = (count_reg != 2'h0);
    assign out_s.data = mem_reg[rd_ptr_reg];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_s.data;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_reg[0] <= DATA_RST;
            mem_reg[1] <= DATA_RST;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end
endmodule // sscb_read_buffer

// [sscb_rd_sink.sv]
// Read-data receiver model that can stall the read stream on command.
`timescale 1ns/100ps
module sscb_rd_sink (
    input wire logic stall_i,
    output logic read_ready_o
);
    // A stalled receiver holds ready low, so words must wait in the buffer.
    assign read_ready_o = !stall_i;
endmodule // sscb_rd_sink

// [sscb_sram_ctrl_props.sv]
// Concurrent checks on the ports of the SRAM bus control block.
`timescale 1ns/100ps
module sscb_sram_ctrl_props #(
    parameter int POWER_WAIT_CYCLES = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic primary_select_n_i,
    input wire logic expansion_select_high_i,
    input wire logic expansion_select_n_i,
    input wire logic cpu_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire logic all_lanes_write_n_i,
    input wire logic lane_write_gate_n_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic data_oe_o,
    input wire logic read_valid_o,
    input wire logic access_ready_o,
    input wire logic sleeping_o
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic sel;
    logic stb;
    assign sel = !primary_select_n_i && expansion_select_high_i
        && !expansion_select_n_i;
    assign stb = !cpu_addr_strobe_n_i || !ctrl_addr_strobe_n_i;
    always_comb begin
        cnt_next = rst_i ? 32'h0 : cnt_reg + 32'(cnt_reg < POWER_WAIT_CYCLES);
    end
    always_ff @(posedge clk_i) begin
        cnt_reg <= cnt_next;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_read;
        sel && stb && all_lanes_write_n_i && lane_write_gate_n_i
            && access_ready_o;
    endsequence
    sequence s_write;
        sel && stb && !all_lanes_write_n_i && access_ready_o;
    endsequence
    chk_wait_idle: assert property (
        cnt_reg < POWER_WAIT_CYCLES |-> !access_ready_o)
        else $error("access ready during power-up wait");
    chk_read_taken: assert property (s_read |=> read_valid_o)
        else $error("selected read not taken");
    chk_desel_none: assert property (
        !sel && !read_valid_o |=> !read_valid_o)
        else $error("access taken while deselected");
    chk_write_hiz: assert property (s_write |=> !data_oe_o)
        else $error("data driven after write");
    chk_oe_async: assert property (output_enable_n_i |-> !data_oe_o)
        else $error("data driven with output enable high");
    chk_sleep_enter: assert property (
        sleep_request_i && access_ready_o |=> sleeping_o)
        else $error("sleep not entered");
    chk_sleep_quiet: assert property (
        sleeping_o |-> !access_ready_o && !data_oe_o)
        else $error("activity during sleep");
    chk_wake_hiz: assert property ($fell(sleeping_o) |-> !data_oe_o)
        else $error("data driven on wake");
    chk_sleep_hold: assert property (
        sleeping_o |=> $stable(read_valid_o))
        else $error("read stream moved during sleep");
    chk_drive_valid: assert property (data_oe_o |-> read_valid_o)
        else $error("data driven without read word");
endmodule // sscb_sram_ctrl_props
bind sscb_sram_ctrl sscb_sram_ctrl_props #(
    .POWER_WAIT_CYCLES(POWER_WAIT_CYCLES)
) i_sscb_sram_ctrl_props (.*);

// [sync_sram_bus_control_tb.sv]
// Self-checking bench for the SRAM bus control block.
`timescale 1ns/100ps
module sync_sram_bus_control_tb;
    localparam logic [2:0] SEL = 3'b010;
    localparam int WAIT_CYC = 8;
    logic clk_i = 1'b0, rst_i = 1'b1, stall = 1'b1, output_enable_n_i = 1'b0;
    logic primary_select_n_i = 1'b1, expansion_select_high_i = 1'b0;
    logic expansion_select_n_i = 1'b1, sleep_request_i = 1'b0;
    logic cpu_addr_strobe_n_i = 1'b1, ctrl_addr_strobe_n_i = 1'b1;
    logic all_lanes_write_n_i = 1'b1, lane_write_gate_n_i = 1'b1;
    logic [18:0] addr_i = 19'h00005;
    logic [3:0] lane_write_n_i = 4'hf;
    logic [35:0] data_i = 36'h0, data_o;
    logic data_oe_o, read_valid_o, access_ready_o, sleeping_o, read_ready_i;
    int n_errors = 0, n_checks = 0;
    sscb_sram_ctrl #(.POWER_WAIT_CYCLES(WAIT_CYC)) i_sscb_sram_ctrl (.*);
    sscb_rd_sink i_sscb_rd_sink (.stall_i(stall), .read_ready_o(read_ready_i));
    always #2 clk_i = !clk_i;
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [2:0] ce, input logic gw, input logic s,
                       input logic [35:0] d);
        @(posedge clk_i);
        {primary_select_n_i, expansion_select_high_i,
         expansion_select_n_i} <= ce;
        cpu_addr_strobe_n_i <= s;
        ctrl_addr_strobe_n_i <= !s;
        all_lanes_write_n_i <= gw;
        data_i <= d;
        @(posedge clk_i);
        cpu_addr_strobe_n_i <= 1'b1;
        ctrl_addr_strobe_n_i <= 1'b1;
        all_lanes_write_n_i <= 1'b1;
    endtask
    task automatic pop();
        @(posedge clk_i) stall <= 1'b0;
        @(posedge clk_i) stall <= 1'b1;
    endtask
    // Leaves the word in the buffer so drive and enable can be probed.
    task automatic rd_hold(input logic [35:0] exp);
        acc(SEL, 1'b1, 1'b1, 36'h0);
        repeat (2) @(posedge clk_i);
        #1 chk(data_o, exp);
    endtask
    task automatic t_power();
        @(posedge clk_i) rst_i <= 1'b0;
        #1 chk(access_ready_o, 0);
        repeat (WAIT_CYC - 1) @(posedge clk_i);
        #1 chk(access_ready_o, 0);
        @(posedge clk_i);
        #1 chk(access_ready_o, 1);
    endtask
    task automatic t_write();
        acc(SEL, 1'b0, 1'b0, 36'h123456789);
        rd_hold(36'h123456789);
        pop();
        @(posedge clk_i) lane_write_gate_n_i <= 1'b0;
        lane_write_n_i <= 4'h0;
        acc(SEL, 1'b1, 1'b1, 36'habcdef012);
        @(posedge clk_i) lane_write_gate_n_i <= 1'b1;
        lane_write_n_i <= 4'hf;
        rd_hold(36'habcdef012);
        chk(data_oe_o, 1);
        pop();
    endtask
    // A partial write at a second address: only lane 2 may change.
    task automatic t_lanes();
        @(posedge clk_i) addr_i <= 19'h00006;
        acc(SEL, 1'b0, 1'b0, 36'h000000000);
        @(posedge clk_i) lane_write_gate_n_i <= 1'b0;
        lane_write_n_i <= 4'hb;
        acc(SEL, 1'b1, 1'b1, 36'hfffffffff);
        @(posedge clk_i) lane_write_gate_n_i <= 1'b1;
        lane_write_n_i <= 4'hf;
        rd_hold(36'h007fc0000);
        pop();
        @(posedge clk_i) addr_i <= 19'h00005;
    endtask
    task automatic t_write_hiz();
        rd_hold(36'habcdef012);
        acc(SEL, 1'b0, 1'b0, 36'h0f0f0f0f0);
        @(posedge clk_i) #1 chk(data_oe_o, 0);
        pop();
    endtask
    task automatic t_desel();
        for (int i = 0; i < 8; i++) begin
            if (i != 2) begin
                // Bit 1 picks read or write, so both are tried deselected.
                acc(3'(i), 1'(i >> 1), 1'(i), 36'(i));
            end
        end
        #1 chk(read_valid_o, 0);
        rd_hold(36'h0f0f0f0f0);
        @(posedge clk_i) output_enable_n_i <= 1'b1;
        #1 chk(data_oe_o, 0);
        @(posedge clk_i) output_enable_n_i <= 1'b0;
        #1 chk(data_oe_o, 1);
        pop();
    endtask
    task automatic t_sleep();
        rd_hold(36'h0f0f0f0f0);
        @(posedge clk_i) primary_select_n_i <= 1'b1;
        sleep_request_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk(sleeping_o, 1);
        pop();
        acc(SEL, 1'b0, 1'b0, 36'h555555555);
        @(posedge clk_i) sleep_request_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk({sleeping_o, data_oe_o}, 0);
        chk(read_valid_o, 1);
        pop();
        rd_hold(36'h0f0f0f0f0);
        pop();
    endtask
    task automatic t_buf();
        repeat (3) acc(SEL, 1'b1, 1'b1, 36'h0);
        #1 chk(access_ready_o, 0);
        @(posedge clk_i) stall <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk(read_valid_o, 0);
        @(posedge clk_i) stall <= 1'b1;
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (7) @(posedge clk_i);
        t_power();
        t_write();
        t_lanes();
        t_write_hiz();
        t_desel();
        t_sleep();
        t_buf();
        tally_and_finish();
    end
    initial begin
        #12000 n_errors++;
        tally_and_finish();
    end
endmodule // sync_sram_bus_control_tb
